// ===== hdl/cacc_module.sv
`timescale 1ns/1ps
`default_nettype none

module cacc_module
(
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire cacc_pkg::cacc_mode_s mode,
	input  wire logic [15:0]          timeBase,
	input  wire logic                 countTick,
	input  wire logic [15:0]          compareValue,
	input  wire logic                 compareLoad,
	input  wire logic                 modulePin,
	output logic                      moduleEvent,
	output logic [15:0]               captureValue,
	output logic                      pinOut
);

	logic [15:0] compareReg;
	logic [7:0]  activeDutyByte;
	logic        pinLast;
	logic        matchHit;
	logic        captureHit;
	logic        wrapLow;

	// ------------------------------------------------------------
	// Compare and capture detection
	// ------------------------------------------------------------
	// Match evaluated only when the base moves, so one hit per count
	assign matchHit   = mode.compareEn & countTick & (timeBase == compareReg);
	assign captureHit = (mode.captureRiseEn & modulePin & ~pinLast)
	                  | (mode.captureFallEn & ~modulePin & pinLast);
	assign wrapLow    = countTick & (timeBase[7:0] == cacc_pkg::CACC_BYTE_MAX);
	assign moduleEvent = (matchHit & mode.matchEn & ~mode.pulseModEn) | captureHit;

	always_ff @(posedge clock)
	begin
		if (rst)
			pinLast <= 1'b0;
		else
			pinLast <= modulePin;
	end

	// Compare pair written by software, capture overwrites it
	always_ff @(posedge clock)
	begin
		if (rst)
			compareReg <= cacc_pkg::CACC_COUNT_RESET;
		else if (captureHit)
			compareReg <= timeBase;
		else if (compareLoad)
			compareReg <= compareValue;
	end

	// Duty byte reloads only on low byte wrap to avoid glitches
	always_ff @(posedge clock)
	begin
		if (rst)
			activeDutyByte <= 8'h00;
		else if (wrapLow)
			activeDutyByte <= compareReg[15:8];
	end

	// ------------------------------------------------------------
	// Output pin: toggle on match, or PWM level
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
			pinOut <= 1'b1;
		else if (mode.pulseModEn && mode.compareEn)
			pinOut <= (timeBase[7:0] >= activeDutyByte);
		else if (matchHit && mode.toggleEn && mode.matchEn)
			pinOut <= ~pinOut;
	end

	assign captureValue = compareReg;

endmodule

`default_nettype wire

// ===== hdl/cacc_pkg.sv
package cacc_pkg;

	// ------------------------------------------------------------
	// Counts, widths and reset values
	// ------------------------------------------------------------
	localparam int          CACC_MODULES     = 2;
	localparam int          CACC_DIV6_COUNT  = 6;
	localparam int          CACC_DIV2_COUNT  = 2;
	localparam logic [15:0] CACC_COUNT_RESET = 16'h0000;
	localparam logic [7:0]  CACC_BYTE_MAX    = 8'hFF;

	// ------------------------------------------------------------
	// Count source selection codes
	// ------------------------------------------------------------
	localparam logic [1:0] CACC_SRC_DIV6 = 2'h0;
	localparam logic [1:0] CACC_SRC_DIV2 = 2'h1;
	localparam logic [1:0] CACC_SRC_T0   = 2'h2;
	localparam logic [1:0] CACC_SRC_EXT  = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CACC_STOPPED,
		CACC_RUNNING,
		CACC_IDLE_HELD
	} cacc_run_e;

	// Per-module mode register
	typedef struct packed {
		logic compareEn;
		logic captureRiseEn;
		logic captureFallEn;
		logic matchEn;
		logic toggleEn;
		logic pulseModEn;
		logic flagIrqEn;
	} cacc_mode_s;

	// Array-wide mode and control bits
	typedef struct packed {
		logic       idleStop;
		logic [1:0] countSourceSel;
		logic       overflowIrqEn;
		logic       counterRun;
	} cacc_array_s;

endpackage

// ===== hdl/cacc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module cacc_prescaler
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       enable,
	input  wire logic [1:0] countSourceSel,
	input  wire logic       timer0Overflow,
	input  wire logic       extCountIn,
	output logic            countTick
);

	logic [2:0] div6Count;
	logic       div2Count;
	logic       extLast;
	logic       next_tick;

	// ------------------------------------------------------------
	// Dividers; they hold while stopped so the phase is kept
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
			div6Count <= 3'h0;
		else if (enable)
			div6Count <= (div6Count == 3'(cacc_pkg::CACC_DIV6_COUNT - 1)) ? 3'h0 : div6Count + 3'h1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			div2Count <= 1'b0;
		else if (enable)
			div2Count <= ~div2Count;
	end

	// Edge memory of the external count pin, sampled always
	always_ff @(posedge clock)
	begin
		if (rst)
			extLast <= 1'b0;
		else
			extLast <= extCountIn;
	end

	// Source select decode
	always_comb
	begin
		case (countSourceSel)
			cacc_pkg::CACC_SRC_DIV6: next_tick = (div6Count == 3'(cacc_pkg::CACC_DIV6_COUNT - 1));
			cacc_pkg::CACC_SRC_DIV2: next_tick = div2Count;
			cacc_pkg::CACC_SRC_T0:   next_tick = timer0Overflow;
			cacc_pkg::CACC_SRC_EXT:  next_tick = extCountIn & ~extLast;
			default:                 next_tick = 1'b0;
		endcase
	end

	assign countTick = enable & next_tick;

endmodule

`default_nettype wire

// ===== hdl/counter_array_capture_compare.sv
// Summary of operation
// - Time base counts one of four sources: clock/6, clock/2, timer 0 overflow, external.
// - One 16-bit counter, high and low bytes, shared by both modules.
// - With idle stop set the counter halts while the core is idle.
// - Counter counts only while run is set; clearing run stops it.
// - Overflow sets a sticky flag cleared only by software; may interrupt.
// - Module flag set by hardware on match or capture; software may clear.
// - Module and overflow requests merge onto one interrupt line.
// - Module flag interrupts only with its flag interrupt enable.
// - Capture falls, rises or both per the two capture enables.
// - Capture copies the time base into capture registers and sets flag.
// - Compare enable turns on the comparator against the compare pair.
// - Match enable sets the module flag when the time base equals compare.
// - Compare plus match enables give a 16-bit software timer.
// - Toggle enable inverts the module pin on each match.
// - High-speed output needs toggle, match and compare enables together.
// - Pulse enable makes the module an 8-bit pulse-width modulator.
// - Unused array pins stay usable as ordinary port pins.
// - PWM low while low byte below duty byte; duty reloads on wrap.
// - Select 01 is clock/2, select 10 is timer 0 overflow.
`timescale 1ns/1ps
`default_nettype none

module counter_array_capture_compare
(
	input  wire logic                  clock,
	input  wire logic                  rst,
	// Array configuration
	input  wire cacc_pkg::cacc_array_s arrayCfg,
	input  wire logic                  coreIdle,
	input  wire logic                  timer0Overflow,
	// Counter load and read
	input  wire logic [15:0]           counterValue,
	input  wire logic                  counterLoad,
	output logic [15:0]                counterNow,
	// Flag handling: clear pulses from software
	input  wire logic                  overflowFlagClear,
	input  wire logic [1:0]            moduleFlagClear,
	output logic                       overflowFlag,
	output logic [1:0]                 moduleFlag,
	output logic                       irqRequest,
	// Module configuration
	input  wire cacc_pkg::cacc_mode_s  moduleMode0,
	input  wire cacc_pkg::cacc_mode_s  moduleMode1,
	input  wire logic [15:0]           compareValue,
	input  wire logic [1:0]            compareLoad,
	output logic [15:0]                captureValue0,
	output logic [15:0]                captureValue1,
	// Port 1 pins
	input  wire logic                  extCountIn,
	input  wire logic [1:0]            modulePinIn,
	input  wire logic [1:0]            portLatch,
	output logic [1:0]                 modulePinOut,
	output logic [1:0]                 modulePinOe
);

	cacc_pkg::cacc_run_e  runState;
	cacc_pkg::cacc_run_e  next_runState;
	cacc_pkg::cacc_mode_s modeOf [cacc_pkg::CACC_MODULES];
	logic [15:0]          timeBase;
	logic                 runEnable;
	logic                 countTick;
	logic                 wrapEvent;
	logic [1:0]           moduleEvent;
	logic [15:0]          capVal [cacc_pkg::CACC_MODULES];
	logic [1:0]           pinDrive;
	logic [1:0]           pinUsed;

	assign modeOf[0] = moduleMode0;
	assign modeOf[1] = moduleMode1;

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	always_comb
	begin
		case (runState)
			cacc_pkg::CACC_STOPPED:
				next_runState = arrayCfg.counterRun ? cacc_pkg::CACC_RUNNING : cacc_pkg::CACC_STOPPED;
			cacc_pkg::CACC_RUNNING:
				if (!arrayCfg.counterRun)
					next_runState = cacc_pkg::CACC_STOPPED;
				else if (arrayCfg.idleStop && coreIdle)
					next_runState = cacc_pkg::CACC_IDLE_HELD;
				else
					next_runState = cacc_pkg::CACC_RUNNING;
			cacc_pkg::CACC_IDLE_HELD:
				if (!arrayCfg.counterRun)
					next_runState = cacc_pkg::CACC_STOPPED;
				else if (!(arrayCfg.idleStop && coreIdle))
					next_runState = cacc_pkg::CACC_RUNNING;
				else
					next_runState = cacc_pkg::CACC_IDLE_HELD;
			default:
				next_runState = cacc_pkg::CACC_STOPPED;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			runState <= cacc_pkg::CACC_STOPPED;
		else
			runState <= next_runState;
	end

	// Gate directly from the bits as well, so stopping takes effect at once
	assign runEnable = (runState != cacc_pkg::CACC_STOPPED) && arrayCfg.counterRun
	                 && !(arrayCfg.idleStop && coreIdle);

	// ------------------------------------------------------------
	// Count source
	// ------------------------------------------------------------
	cacc_prescaler u_prescaler
	(
		.clock          (clock),
		.rst            (rst),
		.enable         (runEnable),
		.countSourceSel (arrayCfg.countSourceSel),
		.timer0Overflow (timer0Overflow),
		.extCountIn     (extCountIn),
		.countTick      (countTick)
	);

	// ------------------------------------------------------------
	// Shared 16-bit time base
	// ------------------------------------------------------------
	assign wrapEvent = countTick && (timeBase == 16'hFFFF);

	always_ff @(posedge clock)
	begin
		if (rst)
			timeBase <= cacc_pkg::CACC_COUNT_RESET;
		else if (counterLoad)
			timeBase <= counterValue; // Software write wins over a count
		else if (countTick)
			timeBase <= timeBase + 16'h0001;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			counterNow <= cacc_pkg::CACC_COUNT_RESET;
		else
			counterNow <= timeBase;
	end

	// Overflow flag: a set in the clear cycle is not lost
	always_ff @(posedge clock)
	begin
		if (rst)
			overflowFlag <= 1'b0;
		else if (wrapEvent)
			overflowFlag <= 1'b1;
		else if (overflowFlagClear)
			overflowFlag <= 1'b0;
	end

	// ------------------------------------------------------------
	// Compare/capture modules
	// ------------------------------------------------------------
	genvar m;
	generate
		for (m = 0; m < cacc_pkg::CACC_MODULES; m++)
		begin : g_module
			cacc_module u_module
			(
				.clock        (clock),
				.rst          (rst),
				.mode         (modeOf[m]),
				.timeBase     (timeBase),
				.countTick    (countTick),
				.compareValue (compareValue),
				.compareLoad  (compareLoad[m]),
				.modulePin    (modulePinIn[m]),
				.moduleEvent  (moduleEvent[m]),
				.captureValue (capVal[m]),
				.pinOut       (pinDrive[m])
			);

			// Flag set wins over a software clear in the same cycle
			always_ff @(posedge clock)
			begin
				if (rst)
					moduleFlag[m] <= 1'b0;
				else if (moduleEvent[m])
					moduleFlag[m] <= 1'b1;
				else if (moduleFlagClear[m])
					moduleFlag[m] <= 1'b0;
			end

			// Pin is the array's only when a toggle or PWM mode uses it
			assign pinUsed[m] = (modeOf[m].toggleEn & modeOf[m].matchEn & modeOf[m].compareEn)
			                  | (modeOf[m].pulseModEn & modeOf[m].compareEn);

			always_ff @(posedge clock)
			begin
				if (rst)
				begin
					modulePinOut[m] <= 1'b1;
					modulePinOe[m]  <= 1'b0;
				end
				else
				begin
					modulePinOut[m] <= pinUsed[m] ? pinDrive[m] : portLatch[m];
					modulePinOe[m]  <= pinUsed[m] | ~portLatch[m];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			captureValue0 <= cacc_pkg::CACC_COUNT_RESET;
			captureValue1 <= cacc_pkg::CACC_COUNT_RESET;
		end
		else
		begin
			captureValue0 <= capVal[0];
			captureValue1 <= capVal[1];
		end
	end

	// ------------------------------------------------------------
	// Shared interrupt request, from the registered flags
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
			irqRequest <= 1'b0;
		else
			irqRequest <= (overflowFlag & arrayCfg.overflowIrqEn)
			            | (moduleFlag[0] & moduleMode0.flagIrqEn)
			            | (moduleFlag[1] & moduleMode1.flagIrqEn);
	end

endmodule

`default_nettype wire

// ===== tb/cacc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checks
// ----
module cacc_asserts
(
	input wire logic                  clock,
	input wire logic                  rst,
	input wire cacc_pkg::cacc_array_s arrayCfg,
	input wire logic                  coreIdle,
	input wire logic                  counterLoad,
	input wire logic [15:0]           counterNow,
	input wire logic                  overflowFlagClear,
	input wire logic [1:0]            moduleFlagClear,
	input wire logic                  overflowFlag,
	input wire logic [1:0]            moduleFlag,
	input wire logic                  irqRequest,
	input wire cacc_pkg::cacc_mode_s  moduleMode0,
	input wire cacc_pkg::cacc_mode_s  moduleMode1,
	input wire logic [1:0]            modulePinIn,
	input wire logic [1:0]            modulePinOe
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Past values across a reset edge are stale, hence the guards
	a_irq_merge: assert property (!$past(rst) |-> irqRequest == $past(overflowFlag & arrayCfg.overflowIrqEn
		| moduleFlag[0] & moduleMode0.flagIrqEn | moduleFlag[1] & moduleMode1.flagIrqEn))
		else $error("irq not from enabled flags");
	a_run_halt: assert property ((!arrayCfg.counterRun && !counterLoad) [*3] |=> $stable(counterNow))
		else $error("count moved while stopped");
	a_idle_halt: assert property ((arrayCfg.idleStop && coreIdle && !counterLoad) [*3] |=> $stable(counterNow))
		else $error("count moved in idle");
	a_count_step: assert property (!$past(rst) && !$past(counterLoad) && !$past(counterLoad, 2)
		&& $changed(counterNow) |-> counterNow == $past(counterNow) + 16'h0001)
		else $error("count did not step by one");
	a_wrap_flag: assert property (!$past(counterLoad) && !$past(counterLoad, 2)
		&& $past(counterNow) == 16'hFFFF && counterNow == 16'h0000 |-> ##[0:1] overflowFlag)
		else $error("wrap without overflow flag");
	a_ovf_sticky: assert property (overflowFlag && !overflowFlagClear |=> overflowFlag)
		else $error("overflow flag dropped");
	a_mod_sticky: assert property (moduleFlag[1] && !moduleFlagClear[1] |=> moduleFlag[1])
		else $error("module flag dropped");
	a_rise_capture: assert property (!$past(rst) && $rose(modulePinIn[0]) && moduleMode0.captureRiseEn
		&& !moduleMode0.compareEn |-> ##[1:3] moduleFlag[0])
		else $error("rising edge not captured");
	// The bench runs fast output on module 1, so watch that one
	a_hso_drive: assert property ((moduleMode1.toggleEn && moduleMode1.matchEn
		&& moduleMode1.compareEn) [*2] |-> modulePinOe[1])
		else $error("output mode pin not driven");
endmodule
bind counter_array_capture_compare cacc_asserts chk (.clock(clock), .rst(rst), .arrayCfg(arrayCfg),
	.coreIdle(coreIdle), .counterLoad(counterLoad), .counterNow(counterNow),
	.overflowFlagClear(overflowFlagClear), .moduleFlagClear(moduleFlagClear), .overflowFlag(overflowFlag),
	.moduleFlag(moduleFlag), .irqRequest(irqRequest), .moduleMode0(moduleMode0), .moduleMode1(moduleMode1),
	.modulePinIn(modulePinIn), .modulePinOe(modulePinOe));
`default_nettype wire

// ===== tb/cacc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin side model
// ----
module cacc_pin_model
(
	input  wire logic       clock,
	input  wire logic [1:0] pinOut,
	input  wire logic [1:0] pinOe,
	output logic [1:0]      pinIn,
	output logic            countIn
);
	logic [1:0] drive = 2'h3;
	// Pulled up, so a pin nobody drives reads high rather than holding a stale level
	assign pinIn = pinOe & pinOut | ~pinOe & drive;
	initial countIn = 1'b0;
	// Count edges three cycles high, three low; slow enough for any edge sampler
	task automatic pulse_ext(input int n);
		repeat (n)
		begin
			@(posedge clock) countIn <= 1'b1;
			repeat (3) @(posedge clock);
			countIn <= 1'b0;
			repeat (2) @(posedge clock);
		end
	endtask
	// Move one pin at a clock edge
	task automatic set_pin(input int i, input logic v);
		@(posedge clock) drive[i] <= v;
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Testbench
// ----
module testbench;
	logic clock, rst, coreIdle, timer0Overflow, counterLoad, overflowFlagClear, overflowFlag, irqRequest, extCountIn;
	logic [1:0] moduleFlagClear, moduleFlag, compareLoad, modulePinIn, portLatch, modulePinOut, modulePinOe;
	logic [15:0] counterValue, counterNow, compareValue, captureValue0, captureValue1;
	cacc_pkg::cacc_array_s cfg;
	cacc_pkg::cacc_mode_s mode0, mode1;
	int errors = 0;
	int compares = 0;
	int exp[4] = '{12, 36, 12, 12};
	counter_array_capture_compare dut (.clock(clock), .rst(rst), .arrayCfg(cfg), .coreIdle(coreIdle),
		.timer0Overflow(timer0Overflow), .counterValue(counterValue), .counterLoad(counterLoad),
		.counterNow(counterNow), .overflowFlagClear(overflowFlagClear), .moduleFlagClear(moduleFlagClear),
		.overflowFlag(overflowFlag), .moduleFlag(moduleFlag), .irqRequest(irqRequest), .moduleMode0(mode0),
		.moduleMode1(mode1), .compareValue(compareValue), .compareLoad(compareLoad),
		.captureValue0(captureValue0), .captureValue1(captureValue1), .extCountIn(extCountIn),
		.modulePinIn(modulePinIn), .portLatch(portLatch), .modulePinOut(modulePinOut), .modulePinOe(modulePinOe));
	cacc_pin_model pm (.clock(clock), .pinOut(modulePinOut), .pinOe(modulePinOe), .pinIn(modulePinIn),
		.countIn(extCountIn));
	// Clock and hang guard
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial
	begin
		cyc(20000);
		errors++;
		report_and_stop();
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	// Free-running sources have an unknown prescaler phase, so allow one count either way
	task automatic near(input logic [15:0] v, input int e);
		check({15'h0, v >= e - 1 && v <= e + 1}, 16'h0001);
	endtask
	task automatic load(input logic [15:0] v);
		@(posedge clock) counterValue <= v;
		counterLoad <= 1'b1;
		@(posedge clock) counterLoad <= 1'b0;
		cyc(2);
	endtask
	task automatic cmp_load(input logic [1:0] m, input logic [15:0] v);
		@(posedge clock) compareValue <= v;
		compareLoad <= m;
		@(posedge clock) compareLoad <= 2'h0;
		cyc(2);
	endtask
	task automatic clr(input logic o, input logic [1:0] m);
		@(posedge clock) overflowFlagClear <= o;
		moduleFlagClear <= m;
		@(posedge clock) overflowFlagClear <= 1'b0;
		moduleFlagClear <= 2'h0;
		cyc(2);
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{rst, coreIdle, timer0Overflow, counterLoad, overflowFlagClear} = 5'h10;
		{moduleFlagClear, compareLoad, counterValue, compareValue} = 36'h0;
		{cfg, mode0, mode1} = 19'h0;
		portLatch = 2'h3;
		cyc(5);
		rst <= 1'b0;
		cyc(2);
		check({overflowFlag, moduleFlag, irqRequest, counterNow}, 16'h0000);
		check({modulePinOe, modulePinOut}, 16'h0003);
		for (int s = 0; s < 4; s++)
		begin
			load(16'h0100);
			cfg <= {1'b0, s[1:0], 2'h1};
			if (s == 3)
				pm.pulse_ext(12);
			else if (s == 2)
				repeat (12)
				begin
					@(posedge clock) timer0Overflow <= 1'b1;
					@(posedge clock) timer0Overflow <= 1'b0;
					cyc(4);
				end
			else
				cyc(72);
			cfg <= 5'h00;
			cyc(4);
			near(counterNow - 16'h0100, exp[s]);
		end
		load(16'h0200);
		coreIdle <= 1'b1;
		cfg <= 5'h15;
		cyc(30);
		check(counterNow, 16'h0200);
		cfg <= 5'h05;
		cyc(30);
		cfg <= 5'h00;
		coreIdle <= 1'b0;
		cyc(4);
		near(counterNow - 16'h0200, 15);
		load(16'hFFFE);
		cfg <= 5'h0F;
		pm.pulse_ext(3);
		cyc(4);
		check(counterNow, 16'h0001);
		check({overflowFlag, irqRequest}, 16'h0003);
		cfg <= 5'h0D;
		cyc(3);
		check({overflowFlag, irqRequest}, 16'h0002);
		clr(1'b1, 2'h0);
		check(overflowFlag, 16'h0000);
		// Timer on module 0, fast output on module 1, one compare value for both
		cfg <= 5'h00;
		mode0 <= 7'h49;
		mode1 <= 7'h4C;
		load(16'h0000);
		cmp_load(2'h3, 16'h0005);
		clr(1'b0, 2'h3);
		cfg <= 5'h0D;
		pm.pulse_ext(7);
		cfg <= 5'h00;
		cyc(4);
		check({moduleFlag, irqRequest}, 16'h0007);
		check({modulePinOe[1], modulePinOut[1]}, 16'h0002);
		clr(1'b0, 2'h1);
		check({moduleFlag, irqRequest}, 16'h0004);
		// Capture: module 0 rising only, module 1 falling only
		mode0 <= 7'h20;
		mode1 <= 7'h10;
		load(16'h1234);
		clr(1'b0, 2'h3);
		pm.set_pin(1, 1'b0);
		pm.set_pin(0, 1'b0);
		cyc(4);
		check(moduleFlag, 16'h0002);
		pm.set_pin(0, 1'b1);
		cyc(4);
		check(moduleFlag, 16'h0003);
		check(captureValue0, 16'h1234);
		check(captureValue1, 16'h1234);
		pm.set_pin(1, 1'b1);
		mode0 <= 7'h00;
		mode1 <= 7'h00;
		portLatch <= 2'h2;
		cyc(3);
		check({modulePinOe, modulePinOut[0]}, 16'h0002);
		portLatch <= 2'h3;
		// PWM with duty byte 80 taken at the low byte wrap
		mode0 <= 7'h42;
		cmp_load(2'h1, 16'h8000);
		load(16'h00F0);
		cfg <= 5'h0D;
		pm.pulse_ext(32);
		cyc(4);
		check({modulePinOe[0], modulePinOut[0]}, 16'h0002);
		pm.pulse_ext(128);
		cyc(4);
		check({modulePinOe[0], modulePinOut[0]}, 16'h0003);
		report_and_stop();
	end
endmodule
`default_nettype wire
